// file: core/cpu_data_transfer_decode.sv
`timescale 1ns/1ps
`include "xfer_defs.svh"
module cpu_data_transfer_decode
(
  // Clock and reset
  input  wire logic              core_clk,
  input  wire logic              reset_n,
  // Instruction stream
  input  wire logic              instr_valid,
  input  wire logic [15:0]       instr_word,
  input  wire logic [31:0]       instr_pc,
  output logic                   instr_ready,
  // Data memory
  output logic                   mem_req,
  output xfer_pkg::mem_cmd_t     mem_cmd,
  input  wire logic              mem_ready,
  input  wire logic [31:0]       mem_rdata,
  // Register writeback view
  output logic                   wb_valid,
  output xfer_pkg::wb_t          wb,
  // Status
  output logic                   retire,
  output logic                   priv_only,
  output logic                   illegal,
  output logic                   load_use_stall,
  output logic                   fetch_stall,
  // Test flag of the status register
  input  wire logic              t_write,
  input  wire logic              t_wdata,
  output logic                   t_flag
);

  ////////////////////////////////////////////////////////////////////////////
  xfer_pkg::state_t state;
  xfer_pkg::state_t next_state;
  xfer_pkg::dec_t   dec;
  logic [15:0]      instr;
  logic [31:0]      pc;
  logic [15:0]      dec_code;
  logic             accept;
  logic             ld_pend;
  logic [3:0]       ld_idx;
  logic             hazard;
  logic [31:0]      src_val;
  logic [31:0]      dst_val;
  logic [31:0]      zero_val;
  logic [31:0]      size_bytes;
  logic [31:0]      next_addr;
  logic [31:0]      next_wdata;
  logic [31:0]      ld_ext;
  logic             is_mem;
  logic             is_load;
  logic             done_mem;
  logic             we_a;
  logic [3:0]       idx_a;
  logic [31:0]      data_a;
  logic             we_b;
  logic [3:0]       idx_b;
  logic [31:0]      data_b;

  assign accept   = (state == xfer_pkg::st_fetch) && instr_valid && instr_ready;
  // Decode the incoming word while fetching so the reads start at once
  assign dec_code = (state == xfer_pkg::st_fetch) ? instr_word : instr;
  assign done_mem = (state == xfer_pkg::st_mem) && mem_req && mem_ready;

  xfer_field_decode u_decode
  (
    .code (dec_code),
    .dec  (dec)
  );

  xfer_gpr_file #(.WIDTH(32), .DEPTH(16)) u_gpr
  (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .src_idx  (dec.src),
    .dst_idx  (dec.dst),
    .we_a     (we_a),
    .idx_a    (idx_a),
    .data_a   (data_a),
    .we_b     (we_b),
    .idx_b    (idx_b),
    .data_b   (data_b),
    .src_val  (src_val),
    .dst_val  (dst_val),
    .zero_val (zero_val)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Operand shaping
  always_comb
  begin
    size_bytes = 32'h0000_0004;
    if (dec.size == xfer_pkg::sz_byte)
      size_bytes = 32'h0000_0001;
    else if (dec.size == xfer_pkg::sz_word)
      size_bytes = 32'h0000_0002;
  end

  always_comb
  begin
    ld_ext = mem_rdata;
    if (mem_cmd.size == xfer_pkg::sz_byte)
      ld_ext = {{24{mem_rdata[7]}}, mem_rdata[7:0]};
    else if (mem_cmd.size == xfer_pkg::sz_word)
      ld_ext = {{16{mem_rdata[15]}}, mem_rdata[15:0]};
  end

  assign is_load = (dec.op == xfer_pkg::op_pcw) || (dec.op == xfer_pkg::op_pcl) ||
                   (dec.op == xfer_pkg::op_ld_ind) || (dec.op == xfer_pkg::op_ld_inc) ||
                   (dec.op == xfer_pkg::op_ld_disp);
  assign is_mem  = is_load || (dec.op == xfer_pkg::op_st_ind) ||
                   (dec.op == xfer_pkg::op_st_dec) || (dec.op == xfer_pkg::op_st_disp) ||
                   (dec.op == xfer_pkg::op_st_idx);

  // Effective address per mode
  always_comb
  begin
    next_addr = src_val;
    case (dec.op)
      // word at PC plus scaled offset
      xfer_pkg::op_pcw:     next_addr = pc + dec.disp;
      // longword at PC plus scaled offset
      xfer_pkg::op_pcl:     next_addr = pc + dec.disp;
      xfer_pkg::op_st_ind:  next_addr = dst_val;
      xfer_pkg::op_st_dec:  next_addr = dst_val - size_bytes;
      xfer_pkg::op_st_disp: next_addr = dst_val + dec.disp;
      xfer_pkg::op_ld_disp: next_addr = src_val + dec.disp;
      xfer_pkg::op_st_idx:  next_addr = zero_val + dst_val;
      default:              next_addr = src_val;
    endcase
  end

  // Store data, narrowed to the operand
  always_comb
  begin
    next_wdata = (dec.src == `XFER_REG_ZERO) ? zero_val : src_val;
    if (dec.size == xfer_pkg::sz_word)
      next_wdata = {16'h0, next_wdata[15:0]};
    else if (dec.size == xfer_pkg::sz_byte)
      next_wdata = {24'h0, next_wdata[7:0]};
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register file writes
  always_comb
  begin
    we_a   = 1'b0;
    idx_a  = dec.dst;
    data_a = '0;
    we_b   = 1'b0;
    idx_b  = dec.src;
    data_b = '0;
    if (state == xfer_pkg::st_exec)
    begin
      if (dec.op == xfer_pkg::op_imm)
      begin
        we_a   = 1'b1;
        data_a = dec.disp;
      end
      else if (dec.op == xfer_pkg::op_mov)
      begin
        we_a   = 1'b1;
        data_a = src_val;
      end
    end
    // nothing commits until the access completes
    else if (done_mem)
    begin
      we_a   = is_load;
      data_a = ld_ext;
      // pointer moves with its own access
      if (dec.op == xfer_pkg::op_ld_inc)
      begin
        we_b   = 1'b1;
        data_b = src_val + size_bytes;
      end
      else if (dec.op == xfer_pkg::op_st_dec)
      begin
        we_b   = 1'b1;
        idx_b  = dec.dst;
        data_b = mem_cmd.addr;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // next instruction reading the loaded register
  assign hazard = ld_pend &&
                  ((dec.rd_src && dec.src == ld_idx) ||
                   (dec.rd_dst && dec.dst == ld_idx) ||
                   (dec.rd_r0 && ld_idx == `XFER_REG_ZERO));

  always_comb
  begin
    next_state = state;
    case (state)
      xfer_pkg::st_fetch:
        if (accept)
          next_state = hazard ? xfer_pkg::st_hold : xfer_pkg::st_exec;
      // Regfile read is redone here, so the loaded value is seen
      xfer_pkg::st_hold:
        next_state = xfer_pkg::st_exec;
      xfer_pkg::st_exec:
        next_state = is_mem ? xfer_pkg::st_mem : xfer_pkg::st_fetch;
      xfer_pkg::st_mem:
        if (done_mem)
          next_state = xfer_pkg::st_fetch;
      default:
        next_state = xfer_pkg::st_fetch;
    endcase
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      state <= xfer_pkg::st_fetch;
    else
      state <= next_state;
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      instr_ready <= 1'b1;
    else
      instr_ready <= (next_state == xfer_pkg::st_fetch);
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      instr <= '0;
      pc    <= '0;
    end
    else if (accept)
    begin
      instr <= instr_word;
      pc    <= instr_pc;
    end
  end

  // Load tag lives for exactly the next instruction
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ld_pend <= 1'b0;
      ld_idx  <= '0;
    end
    else if (done_mem)
    begin
      ld_pend <= is_load;
      ld_idx  <= dec.dst;
    end
    else if (accept)
      ld_pend <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Memory port
  // one shared path: fetch waits behind a data access
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      mem_req <= 1'b0;
      mem_cmd <= '0;
    end
    else if (state == xfer_pkg::st_exec && is_mem)
    begin
      mem_req       <= 1'b1;
      mem_cmd.we    <= !is_load;
      mem_cmd.size  <= dec.size;
      mem_cmd.addr  <= next_addr;
      mem_cmd.wdata <= is_load ? 32'h0000_0000 : next_wdata;
    end
    else if (done_mem)
      mem_req <= 1'b0;
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      fetch_stall <= 1'b0;
    else
      fetch_stall <= instr_valid && (next_state == xfer_pkg::st_mem);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Retirement view
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wb_valid <= 1'b0;
      wb       <= '0;
    end
    else
    begin
      wb_valid  <= we_a;
      wb.idx    <= idx_a;
      wb.value  <= data_a;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      retire         <= 1'b0;
      illegal        <= 1'b0;
      priv_only      <= 1'b0;
      load_use_stall <= 1'b0;
    end
    else
    begin
      retire         <= done_mem || (state == xfer_pkg::st_exec && !is_mem &&
                                     dec.op != xfer_pkg::op_bad);
      illegal        <= (state == xfer_pkg::st_exec) && (dec.op == xfer_pkg::op_bad);
      if (state == xfer_pkg::st_exec)
        priv_only    <= dec.priv;
      load_use_stall <= (next_state == xfer_pkg::st_hold);
    end
  end

  // only an outside write moves the flag
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      t_flag <= `XFER_T_RESET;
    else if (t_write && state == xfer_pkg::st_fetch)
      t_flag <= t_wdata;
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  a_imm_sign_ext: assert property (
    state == xfer_pkg::st_exec && dec.op == xfer_pkg::op_imm
    |=> wb_valid && wb.value == {{24{$past(instr[7])}}, $past(instr[7:0])})
    else $error("immediate not sign-extended");
  a_mov_copy: assert property (
    state == xfer_pkg::st_exec && dec.op == xfer_pkg::op_mov
    |=> wb_valid && wb.value == $past(src_val) && retire)
    else $error("register move value wrong");
  a_pcw_addr: assert property (
    state == xfer_pkg::st_exec && dec.op == xfer_pkg::op_pcw
    |=> mem_req && mem_cmd.addr == $past(pc) + {23'h0, $past(instr[7:0]), 1'b0})
    else $error("pc word address wrong");
  a_predec_addr: assert property (
    state == xfer_pkg::st_exec && dec.op == xfer_pkg::op_st_dec
    |=> mem_cmd.we && mem_cmd.addr == $past(dst_val) - $past(size_bytes))
    else $error("pre-decrement address wrong");
  a_disp_scale: assert property (
    state == xfer_pkg::st_exec && dec.op == xfer_pkg::op_ld_disp
    && dec.size == xfer_pkg::sz_word
    |=> mem_cmd.addr == $past(src_val) + {27'h0, $past(instr[3:0]), 1'b0})
    else $error("word displacement not doubled");
  a_wait_hold: assert property (
    mem_req && !mem_ready
    |=> mem_req && $stable(mem_cmd) && !retire && !wb_valid)
    else $error("state moved during wait");
  a_load_stall: assert property (
    accept && hazard
    |=> load_use_stall ##1 state == xfer_pkg::st_exec)
    else $error("load-use stall missing");
  a_t_unchanged: assert property (
    state != xfer_pkg::st_fetch |=> $stable(t_flag))
    else $error("test flag changed");
  a_priv_clear: assert property (
    retire |-> !priv_only)
    else $error("move flagged privileged");
  a_fetch_block: assert property (
    mem_req |-> !instr_ready)
    else $error("fetch taken during data access");

  c_load_done:  cover property (done_mem && !mem_cmd.we);
  c_wait_state: cover property (mem_req && !mem_ready ##1 mem_req && mem_ready);
  c_load_use:   cover property (load_use_stall);
  c_post_inc:   cover property (done_mem && dec.op == xfer_pkg::op_ld_inc);
endmodule // cpu_data_transfer_decode

// file: core/xfer_defs.svh
`ifndef XFER_DEFS_SVH
`define XFER_DEFS_SVH
// Functional notes
// - Source index from bits 7:4, destination from 11:8; zero means register 0.
// - Cycle counts are minimums; memory contention adds cycles.
// - A register loaded by memory stalls the next instruction if that one reads it.
// - These moves never change the test flag.
// - Displacements scale by one, two or four with operand size.
// - Move-immediate sign-extends eight bits into the destination, one cycle.
// - PC-relative word load at PC plus offset times two, sign-extended.
// - PC-relative longword load at PC plus offset times four, unchanged.
// - Register move copies all 32 source bits, one cycle.
// - Indirect store writes source to address in destination; size in low nibble.
// - Indirect load from source address; byte and word sign-extended.
// - Pre-decrement store lowers destination by size, then stores there.
// - Post-increment load reads, sign-extends, then advances source by size.
// - Byte or word store of register zero at destination plus scaled offset.
// - Longword store of any source at destination plus offset times four.
// - Byte or word displacement load always lands in register zero.
// - Longword displacement load lands in any destination.
// - Indexed byte store writes low byte at register zero plus destination.
// - Privileged flag reported per instruction; all moves are unprivileged.
// - Indexed word store writes low half at register zero plus destination.
`define XFER_GRP_IDX    4'h0
`define XFER_GRP_STDL   4'h1
`define XFER_GRP_ST     4'h2
`define XFER_GRP_LDDL   4'h5
`define XFER_GRP_LD     4'h6
`define XFER_GRP_DISP   4'h8
`define XFER_GRP_PCW    4'h9
`define XFER_GRP_PCL    4'hd
`define XFER_GRP_IMM    4'he
`define XFER_SUB_MOV    4'h3
`define XFER_SUB_IDXB   4'h4
`define XFER_SUB_IDXW   4'h5
`define XFER_SUB_DSTB   4'h0
`define XFER_SUB_DSTW   4'h1
`define XFER_SUB_DLDB   4'h4
`define XFER_SUB_DLDW   4'h5
`define XFER_REG_ZERO   4'h0
`define XFER_T_RESET    1'b0
`endif

// file: core/xfer_pkg.sv
package xfer_pkg;
  typedef enum logic [1:0] {sz_byte = 2'b00, sz_word = 2'b01, sz_long = 2'b10} size_t;
  typedef enum logic [3:0] {
    op_bad = 4'h0, op_imm = 4'h1, op_pcw = 4'h2, op_pcl = 4'h3,
    op_mov = 4'h4, op_st_ind = 4'h5, op_ld_ind = 4'h6, op_st_dec = 4'h7,
    op_ld_inc = 4'h8, op_st_disp = 4'h9, op_ld_disp = 4'ha, op_st_idx = 4'hb
  } op_t;
  typedef enum logic [1:0] {
    st_fetch = 2'b00, st_hold = 2'b01, st_exec = 2'b10, st_mem = 2'b11
  } state_t;
  typedef struct packed {
    op_t         op;
    size_t       size;
    logic [3:0]  src;
    logic [3:0]  dst;
    logic [31:0] disp;
    logic        rd_src;
    logic        rd_dst;
    logic        rd_r0;
    logic        priv;
  } dec_t;
  typedef struct packed {
    logic        we;
    size_t       size;
    logic [31:0] addr;
    logic [31:0] wdata;
  } mem_cmd_t;
  typedef struct packed {
    logic [3:0]  idx;
    logic [31:0] value;
  } wb_t;
endpackage

// file: core/xfer_field_decode.sv
`timescale 1ns/1ps
`include "xfer_defs.svh"
module xfer_field_decode
(
  // Code word
  input  wire logic [15:0]   code,
  // Decoded fields
  output xfer_pkg::dec_t     dec
);
  always_comb
  begin
    dec        = '0;
    dec.src    = code[7:4];
    dec.dst    = code[11:8];
    dec.size   = xfer_pkg::size_t'({1'b0, code[0]});
    if (code[1])
      dec.size = xfer_pkg::sz_long;
    dec.rd_src = 1'b1;
    dec.priv   = 1'b0;
    case (code[15:12])
      `XFER_GRP_IMM:
      begin
        dec.op     = xfer_pkg::op_imm;
        dec.rd_src = 1'b0;
        dec.disp   = {{24{code[7]}}, code[7:0]};
      end
      `XFER_GRP_PCW:
      begin
        dec.op     = xfer_pkg::op_pcw;
        dec.size   = xfer_pkg::sz_word;
        dec.rd_src = 1'b0;
        dec.disp   = {23'h0, code[7:0], 1'b0};
      end
      `XFER_GRP_PCL:
      begin
        dec.op     = xfer_pkg::op_pcl;
        dec.size   = xfer_pkg::sz_long;
        dec.rd_src = 1'b0;
        dec.disp   = {22'h0, code[7:0], 2'b00};
      end
      `XFER_GRP_LD:
      begin
        if (code[3:0] == `XFER_SUB_MOV)
          dec.op = xfer_pkg::op_mov;
        else if (code[3:2] == 2'b00 && code[1:0] != 2'b11)
          dec.op = xfer_pkg::op_ld_ind;
        else if (code[3:2] == 2'b01 && code[1:0] != 2'b11)
          dec.op = xfer_pkg::op_ld_inc;
      end
      `XFER_GRP_ST:
      begin
        dec.rd_dst = 1'b1;
        if (code[3:2] == 2'b00 && code[1:0] != 2'b11)
          dec.op = xfer_pkg::op_st_ind;
        else if (code[3:2] == 2'b01 && code[1:0] != 2'b11)
          dec.op = xfer_pkg::op_st_dec;
      end
      `XFER_GRP_STDL, `XFER_GRP_LDDL:
      begin
        dec.disp   = {26'h0, code[3:0], 2'b00};
        dec.size   = xfer_pkg::sz_long;
        dec.rd_dst = (code[15:12] == `XFER_GRP_STDL);
        dec.op     = dec.rd_dst ? xfer_pkg::op_st_disp : xfer_pkg::op_ld_disp;
      end
      `XFER_GRP_DISP:
      begin
        // register zero data, base in bits 7:4
        dec.dst  = code[7:4];
        dec.size = xfer_pkg::size_t'({1'b0, code[8]});
        dec.disp = code[8] ? {27'h0, code[3:0], 1'b0} : {28'h0, code[3:0]};
        if (code[11:8] == `XFER_SUB_DSTB || code[11:8] == `XFER_SUB_DSTW)
        begin
          dec.op     = xfer_pkg::op_st_disp;
          dec.src    = `XFER_REG_ZERO;
          dec.rd_src = 1'b0;
          dec.rd_dst = 1'b1;
          dec.rd_r0  = 1'b1;
        end
        else if (code[11:8] == `XFER_SUB_DLDB || code[11:8] == `XFER_SUB_DLDW)
        begin
          dec.op  = xfer_pkg::op_ld_disp;
          dec.src = code[7:4];
          dec.dst = `XFER_REG_ZERO;
        end
      end
      `XFER_GRP_IDX:
      begin
        dec.rd_dst = 1'b1;
        dec.rd_r0  = 1'b1;
        if (code[3:0] == `XFER_SUB_IDXB || code[3:0] == `XFER_SUB_IDXW)
          dec.op = xfer_pkg::op_st_idx;
      end
      default:
        dec.op = xfer_pkg::op_bad;
    endcase
  end
endmodule // xfer_field_decode

// file: core/xfer_gpr_file.sv
`timescale 1ns/1ps
module xfer_gpr_file
#(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
)
(
  // Clock and reset
  input  wire logic                     core_clk,
  input  wire logic                     reset_n,
  // Read indices
  input  wire logic [$clog2(DEPTH)-1:0] src_idx,
  input  wire logic [$clog2(DEPTH)-1:0] dst_idx,
  // Data write port, wins on a clash
  input  wire logic                     we_a,
  input  wire logic [$clog2(DEPTH)-1:0] idx_a,
  input  wire logic [WIDTH-1:0]         data_a,
  // Address adjust port
  input  wire logic                     we_b,
  input  wire logic [$clog2(DEPTH)-1:0] idx_b,
  input  wire logic [WIDTH-1:0]         data_b,
  // Registered read data
  output logic      [WIDTH-1:0]         src_val,
  output logic      [WIDTH-1:0]         dst_val,
  output logic      [WIDTH-1:0]         zero_val
);
  logic [WIDTH-1:0] regs [DEPTH];

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      for (int i = 0; i < DEPTH; i++)
        regs[i] <= '0;
    end
    else
    begin
      if (we_b)
        regs[idx_b] <= data_b;
      if (we_a)
        regs[idx_a] <= data_a;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      src_val  <= '0;
      dst_val  <= '0;
      zero_val <= '0;
    end
    else
    begin
      src_val  <= regs[src_idx];
      dst_val  <= regs[dst_idx];
      zero_val <= regs[0];
    end
  end
endmodule // xfer_gpr_file

// file: dv/xfer_mem_model.sv
`timescale 1ns/1ps
module xfer_mem_model
(
  // Clock
  input  wire logic               core_clk,
  // Data access
  input  wire logic               mem_req,
  input  wire xfer_pkg::mem_cmd_t mem_cmd,
  output logic                    mem_ready,
  output logic [31:0]             mem_rdata,
  // Wait states for each access
  input  wire logic [3:0]         waits
);
  logic [7:0]  mem [0:255];
  logic [3:0]  cnt;
  logic [31:0] last;
  logic [7:0]  a;
  initial
  begin
    cnt = 4'h0;
    last = 32'h0;
    foreach (mem[i]) mem[i] = 8'h0;
  end
  assign a = mem_cmd.addr[7:0];
  assign mem_ready = mem_req && cnt == waits;
  // Idle bus shows the inverse of the last value, so a store just after a read leaves that read showing
  always_comb
  begin
    mem_rdata = ~last;
    if (mem_ready && !mem_cmd.we)
      case (mem_cmd.size)
        xfer_pkg::sz_byte: mem_rdata = {24'h0, mem[a]};
        xfer_pkg::sz_word: mem_rdata = {16'h0, mem[a], mem[a+8'h1]};
        default: mem_rdata = {mem[a], mem[a+8'h1], mem[a+8'h2], mem[a+8'h3]};
      endcase
  end
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge core_clk)
  begin
    cnt <= (mem_req && !mem_ready) ? cnt + 4'h1 : 4'h0;
    if (mem_ready)
    begin
      last <= mem_rdata;
      if (mem_cmd.we && mem_cmd.size == xfer_pkg::sz_byte)
        mem[a] <= mem_cmd.wdata[7:0];
      else if (mem_cmd.we && mem_cmd.size == xfer_pkg::sz_word)
        {mem[a], mem[a+8'h1]} <= mem_cmd.wdata[15:0];
      else if (mem_cmd.we)
        {mem[a], mem[a+8'h1], mem[a+8'h2], mem[a+8'h3]} <= mem_cmd.wdata;
    end
  end
endmodule // xfer_mem_model

// file: dv/cpu_data_transfer_decode_test.sv
`timescale 1ns/1ps
module cpu_data_transfer_decode_test;
  logic               core_clk, reset_n, instr_valid, instr_ready;
  logic [15:0]        instr_word;
  logic [31:0]        instr_pc;
  logic               mem_req, mem_ready, wb_valid, retire, priv_only;
  logic               illegal, load_use_stall, fetch_stall, t_write, t_wdata, t_flag;
  logic [31:0]        mem_rdata;
  logic [3:0]         waits;
  xfer_pkg::mem_cmd_t mem_cmd, cmd_last;
  xfer_pkg::wb_t      wb, wb_last;
  int                 n, base, s0, cyc, stalls, err_total, samples_checked;
  cpu_data_transfer_decode u_dut (.core_clk(core_clk), .reset_n(reset_n),
    .instr_valid(instr_valid), .instr_word(instr_word), .instr_pc(instr_pc),
    .instr_ready(instr_ready), .mem_req(mem_req), .mem_cmd(mem_cmd),
    .mem_ready(mem_ready), .mem_rdata(mem_rdata), .wb_valid(wb_valid), .wb(wb),
    .retire(retire), .priv_only(priv_only), .illegal(illegal),
    .load_use_stall(load_use_stall), .fetch_stall(fetch_stall),
    .t_write(t_write), .t_wdata(t_wdata), .t_flag(t_flag));
  xfer_mem_model u_mem (.core_clk(core_clk), .mem_req(mem_req), .mem_cmd(mem_cmd),
    .mem_ready(mem_ready), .mem_rdata(mem_rdata), .waits(waits));
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    if (mem_req === 1'b1 && mem_ready === 1'b1)
      cmd_last <= mem_cmd;
    if (load_use_stall === 1'b1)
      stalls <= stalls + 1;
    // Ceiling well above the hundred or so cycles the tests take
    if (cyc == 5000)
    begin
      err_total++;
      finish_test();
    end
  end
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask
  // Called at a falling edge; returns at the falling edge where retire shows
  task automatic exe(input logic [15:0] code);
    while (instr_ready !== 1'b1) @(negedge core_clk);
    instr_valid = 1'b1;
    instr_word = code;
    @(negedge core_clk);
    instr_valid = 1'b0;
    n = 1;
    while (retire !== 1'b1 && n < 40)
    begin
      @(negedge core_clk);
      n++;
    end
    if (wb_valid === 1'b1) wb_last = wb;
  endtask
  task automatic t_move;
    exe(16'he380);
    base = n;
    chk("imm value", 32'hffffff80, wb_last.value);
    chk("imm index", 32'h3, {28'h0, wb_last.idx});
    exe(16'h6533);
    chk("mov value", 32'hffffff80, wb_last.value);
    chk("mov cycles", base, n);
    chk("privileged", 32'h0, {31'h0, priv_only});
  endtask
  task automatic t_indirect;
    exe(16'he240);
    exe(16'h2232);
    s0 = n;
    chk("store addr", 32'h40, cmd_last.addr);
    chk("store data", 32'hffffff80, {u_mem.mem[64], u_mem.mem[65], u_mem.mem[66],
      u_mem.mem[67]});
    waits = 4'h3;
    exe(16'h2232);
    chk("wait cycles", s0 + 3, n);
    waits = 4'h0;
    u_mem.mem[8'h50] = 8'h9a;
    u_mem.mem[8'h51] = 8'hbc;
    exe(16'he450);
    exe(16'h6642);
    chk("load long", 32'h9abc0000, wb_last.value);
    exe(16'h6640);
    chk("load byte", 32'hffffff9a, wb_last.value);
    exe(16'h6533);
    chk("no hazard", base, n);
    s0 = stalls;
    exe(16'h6640);
    exe(16'h6763);
    chk("hazard cycles", base + 1, n);
    chk("hazard pulse", s0 + 1, stalls);
    chk("hazard value", 32'hffffff9a, wb_last.value);
  endtask
  task automatic t_adjust;
    exe(16'h2236);
    chk("predec addr", 32'h3c, cmd_last.addr);
    exe(16'h6823);
    chk("predec reg", 32'h3c, wb_last.value);
    exe(16'h6945);
    chk("postinc value", 32'hffff9abc, wb_last.value);
    exe(16'h6a43);
    chk("postinc reg", 32'h52, wb_last.value);
  endtask
  task automatic t_disp;
    u_mem.mem[8'h56] = 8'h80;
    u_mem.mem[8'h57] = 8'h01;
    exe(16'h1231);
    chk("disp long st", 32'h40, cmd_last.addr);
    exe(16'h8542);
    chk("disp word addr", 32'h56, cmd_last.addr);
    chk("disp word r0", 32'h0, {28'h0, wb_last.idx});
    chk("disp word val", 32'hffff8001, wb_last.value);
    exe(16'h8023);
    chk("disp byte st", 32'h3f, cmd_last.addr);
    chk("disp byte data", 32'h01, {24'h0, u_mem.mem[8'h3f]});
    exe(16'h5d41);
    chk("disp long ld", 32'h80010000, wb_last.value);
    chk("disp ld index", 32'hd, {28'h0, wb_last.idx});
  endtask
  task automatic t_pcrel_index;
    instr_pc = 32'h100;
    u_mem.mem[8'h04] = 8'hff;
    u_mem.mem[8'h05] = 8'hfe;
    exe(16'h9b02);
    chk("pc word addr", 32'h104, cmd_last.addr);
    chk("pc word val", 32'hfffffffe, wb_last.value);
    exe(16'hdc01);
    chk("pc long val", 32'hfffe0000, wb_last.value);
    exe(16'h0234);
    chk("idx byte addr", 32'hffff803d, cmd_last.addr);
    chk("idx byte data", 32'h80, {24'h0, u_mem.mem[8'h3d]});
    exe(16'h0235);
    chk("idx word data", 32'hff80, {16'h0, u_mem.mem[8'h3d], u_mem.mem[8'h3e]});
  endtask
  // Size nibble 11 is refused; a word offered during a data access waits
  task automatic t_refuse;
    instr_valid = 1'b1;
    instr_word = 16'h2233;
    @(negedge core_clk);
    instr_valid = 1'b0;
    @(negedge core_clk);
    chk("illegal", 32'h1, {31'h0, illegal});
    chk("illegal retire", 32'h0, {31'h0, retire});
    chk("illegal write", 32'h0, {31'h0, wb_valid});
    waits = 4'h2;
    instr_valid = 1'b1;
    instr_word = 16'h2232;
    @(negedge core_clk);
    instr_word = 16'h6533;
    @(negedge core_clk);
    chk("fetch stall", 32'h1, {31'h0, fetch_stall});
    chk("fetch refused", 32'h0, {31'h0, instr_ready});
    instr_valid = 1'b0;
    repeat (3) @(negedge core_clk);
    chk("stall retire", 32'h1, {31'h0, retire});
    waits = 4'h0;
  endtask
  task automatic t_test_flag;
    t_write = 1'b1;
    t_wdata = 1'b1;
    @(negedge core_clk);
    t_write = 1'b0;
    @(negedge core_clk);
    exe(16'h2232);
    exe(16'h6640);
    exe(16'h6533);
    chk("test flag", 32'h1, {31'h0, t_flag});
  endtask
  task automatic finish_test;
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  initial
  begin
    {reset_n, instr_valid, t_write, t_wdata, cyc, stalls} = '0;
    {err_total, samples_checked, waits, instr_word, instr_pc} = '0;
    repeat (6) @(negedge core_clk);
    reset_n = 1'b1;
    t_move();
    t_indirect();
    t_adjust();
    t_disp();
    t_pcrel_index();
    t_refuse();
    t_test_flag();
    finish_test();
  end
endmodule // cpu_data_transfer_decode_test
